// *** core/ebm_port.sv ***
// external byte memory port: one byte read or write per transfer request
// assumes port registers live outside; this block muxes the shared pins

`include "ebm_regs.svh"

module ebm_port (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic byte_transfer_instruction,
  input wire logic xfer_write,
  input wire logic [15:0] xfer_address,
  input wire logic [7:0] xfer_wdata,
  output logic xfer_busy,
  output logic xfer_done,
  output logic xfer_refused,
  output logic [7:0] xfer_rdata,
  input wire logic voice_busy,
  input wire logic voice_ext_mem,
  input wire logic [2:0] voice_upper_address,
  output logic voice_blocked,
  input wire logic address_ports_secondary_sel,
  input wire logic strobe_port_secondary_sel,
  input wire logic data_ports_secondary_sel,
  input wire logic [15:0] addr_port_out,
  input wire logic [15:0] addr_port_oe,
  input wire logic [7:0] data_port_out,
  input wire logic [7:0] data_port_oe,
  input wire logic [3:0] port8_output_data,
  input wire logic [3:0] port8_direction,
  input wire logic [3:0] portf_output_data,
  input wire logic [3:0] portf_direction,
  output logic [15:0] addr_pin_o,
  output logic [15:0] addr_pin_oe,
  input wire logic [7:0] data_pin_i,
  output logic [7:0] data_pin_o,
  output logic [7:0] data_pin_oe,
  output logic [3:0] port8_pin_o,
  output logic [3:0] port8_pin_oe,
  output logic [3:0] portf_pin_o,
  output logic [3:0] portf_pin_oe,
  output logic rom_req,
  output logic [16:0] rom_address,
  input wire logic [7:0] rom_rdata,
  output logic ports_locked
);
  localparam ebm_pkg::ebm_cnt_t SETUP_CYC = 4'(`EBM_SETUP_CYC);
  localparam ebm_pkg::ebm_cnt_t STROBE_CYC = 4'(`EBM_STROBE_CYC);
  localparam ebm_pkg::ebm_cnt_t HOLD_CYC = 4'(`EBM_HOLD_CYC);

  ebm_pkg::ebm_state_e state_r, state_nxt;
  ebm_pkg::ebm_cnt_t cnt_r, cnt_nxt;
  logic write_r, write_nxt;
  logic rom_r, rom_nxt;
  logic [16:0] addr_r, addr_nxt;
  logic [7:0] wdata_r, wdata_nxt;
  logic [7:0] rdata_r, rdata_nxt;
  logic [2:0] dsync_r [8];
  logic [7:0] data_in;
  logic done_r, done_nxt;
  logic refused_r, refused_nxt;
  logic sel_upper, sel_lower, sel_rom, sel_ext, sel_valid;
  logic active, rd_strobe, wr_strobe;
  logic ext_active, drive_addr, drive_data;
  logic rd_pin_n, wr_pin_n;
  logic rd_capture, start_bad;

  // three-stage sync of data pins; a change counts when stages 2 and 3 agree
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : g_dsync
      logic [2:0] sync_nxt;
      logic filt_r, filt_nxt;
      always_comb begin
        sync_nxt = {dsync_r[gi][1:0], data_pin_i[gi]};
        filt_nxt = filt_r;
        if (dsync_r[gi][1] == dsync_r[gi][2]) begin
          filt_nxt = dsync_r[gi][2];
        end
      end
      always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
          dsync_r[gi] <= 3'h0;
          filt_r <= 1'b0;
        end else begin
          dsync_r[gi] <= sync_nxt;
          filt_r <= filt_nxt;
        end
      end
      assign data_in[gi] = filt_r;
    end
  endgenerate

  always_comb begin
    sel_upper = port8_output_data[`EBM_SEL_UPPER_BIT];
    sel_lower = port8_output_data[`EBM_SEL_LOWER_BIT];
    sel_rom = !sel_upper && sel_lower;
    sel_ext = sel_upper && sel_lower;
    sel_valid = sel_rom || sel_ext;
    active = (state_r != ebm_pkg::EBM_IDLE) && (state_r != ebm_pkg::EBM_DONE);
    rd_strobe = (state_r == ebm_pkg::EBM_STROBE) && !write_r;
    wr_strobe = (state_r == ebm_pkg::EBM_STROBE) && write_r && !rom_r;
    ext_active = active && !rom_r;
    drive_addr = ext_active && address_ports_secondary_sel;
    drive_data = ext_active && data_ports_secondary_sel;
    // rom reads leave the external read strobe idle
    rd_pin_n = !(rd_strobe && !rom_r);
    wr_pin_n = !wr_strobe;
    rd_capture = (state_r == ebm_pkg::EBM_STROBE) && (cnt_r == 4'h1) && !write_r;
    // voice access running, bad select, or write into rom
    start_bad = voice_busy || !sel_valid || (sel_rom && xfer_write);
  end

  // transfer sequencer: setup, strobe, hold, then wait for request drop

  always_comb begin
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    write_nxt = write_r;
    rom_nxt = rom_r;
    addr_nxt = addr_r;
    wdata_nxt = wdata_r;
    done_nxt = 1'b0;
    refused_nxt = 1'b0;
    unique case (state_r)
      ebm_pkg::EBM_IDLE: begin
        if (byte_transfer_instruction) begin
          // no start during voice access; bad select or rom write refused
          if (start_bad) begin
            refused_nxt = 1'b1;
          end else begin
            rom_nxt = sel_rom;
            write_nxt = xfer_write;
            // rom address bit 16 from port f bit 0
            addr_nxt = {sel_rom & portf_output_data[`EBM_ROM_MSB_BIT], xfer_address};
            wdata_nxt = xfer_wdata;
            cnt_nxt = SETUP_CYC;
            state_nxt = ebm_pkg::EBM_SETUP;
          end
        end
      end
      ebm_pkg::EBM_SETUP: begin
        if (cnt_r == 4'h1) begin
          cnt_nxt = STROBE_CYC;
          state_nxt = ebm_pkg::EBM_STROBE;
        end else begin
          cnt_nxt = cnt_r - 4'h1;
        end
      end
      ebm_pkg::EBM_STROBE: begin
        if (cnt_r == 4'h1) begin
          cnt_nxt = HOLD_CYC;
          state_nxt = ebm_pkg::EBM_HOLD;
        end else begin
          cnt_nxt = cnt_r - 4'h1;
        end
      end
      ebm_pkg::EBM_HOLD: begin
        if (cnt_r == 4'h1) begin
          done_nxt = 1'b1;
          state_nxt = ebm_pkg::EBM_DONE;
        end else begin
          cnt_nxt = cnt_r - 4'h1;
        end
      end
      ebm_pkg::EBM_DONE: begin
        // single byte cycle; wait for request to drop
        if (!byte_transfer_instruction) begin
          state_nxt = ebm_pkg::EBM_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      state_r <= ebm_pkg::EBM_IDLE;
      cnt_r <= 4'h0;
      write_r <= 1'b0;
      rom_r <= 1'b0;
      addr_r <= 17'h00000;
      wdata_r <= 8'h00;
      done_r <= 1'b0;
      refused_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      write_r <= write_nxt;
      rom_r <= rom_nxt;
      addr_r <= addr_nxt;
      wdata_r <= wdata_nxt;
      done_r <= done_nxt;
      refused_r <= refused_nxt;
    end
  end

  // read byte register: rom or synced pins at the strobe's last cycle
  always_comb begin
    rdata_nxt = rdata_r;
    if (rd_capture) begin
      // taken at strobe trailing edge; same timing for rom
      rdata_nxt = rom_r ? rom_rdata : data_in;
    end
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      rdata_r <= `EBM_RDATA_RST;
    end else begin
      rdata_r <= rdata_nxt;
    end
  end

  // status outputs
  assign xfer_busy = active;
  assign xfer_done = done_r;
  assign xfer_refused = refused_r;
  assign xfer_rdata = rdata_r;
  assign voice_blocked = active;
  assign rom_req = active && rom_r;
  assign rom_address = addr_r;
  assign ports_locked = sel_rom;

  // address pins
  always_comb begin
    // ports follow their own settings outside transfers while rom is not selected
    addr_pin_o = addr_port_out;
    addr_pin_oe = addr_port_oe;
    if (sel_rom) begin
      // access ports unavailable as ordinary ports
      addr_pin_oe = 16'h0000;
    end
    if (drive_addr) begin
      addr_pin_o = addr_r[15:0];
      addr_pin_oe = 16'hffff;
    end
  end

  // data pins
  always_comb begin
    data_pin_o = data_port_out;
    data_pin_oe = data_port_oe;
    if (sel_rom) begin
      data_pin_oe = 8'h00;
    end
    if (drive_data) begin
      data_pin_o = wdata_r;
      data_pin_oe = {8{write_r}};
    end
  end

  // strobe port
  always_comb begin
    port8_pin_o = port8_output_data;
    port8_pin_oe = port8_direction;
    if (strobe_port_secondary_sel) begin
      // strobe role held whenever selected; active low
      port8_pin_o[`EBM_RD_BIT] = rd_pin_n;
      port8_pin_o[`EBM_WR_BIT] = wr_pin_n;
      port8_pin_oe[`EBM_RD_BIT] = 1'b1;
      port8_pin_oe[`EBM_WR_BIT] = 1'b1;
    end
  end

  // port f: upper voice address while voice uses external memory
  always_comb begin
    portf_pin_o = portf_output_data;
    portf_pin_oe = portf_direction;
    if (voice_ext_mem) begin
      portf_pin_o[2:0] = voice_upper_address;
      portf_pin_oe[2:0] = 3'h7;
    end
  end
endmodule

// *** inc/ebm_regs.svh ***
// timing and field constants of the external byte memory port
// assumes inclusion by bare name from core files
`ifndef EBM_REGS_SVH
`define EBM_REGS_SVH
`define EBM_CLK_MHZ 100
`define EBM_SETUP_NS 20
`define EBM_STROBE_NS 60
`define EBM_HOLD_NS 20
`define EBM_SETUP_CYC ((`EBM_SETUP_NS * `EBM_CLK_MHZ + 999) / 1000)
`define EBM_STROBE_CYC ((`EBM_STROBE_NS * `EBM_CLK_MHZ + 999) / 1000)
`define EBM_HOLD_CYC ((`EBM_HOLD_NS * `EBM_CLK_MHZ + 999) / 1000)
`define EBM_SEL_UPPER_BIT 3
`define EBM_SEL_LOWER_BIT 2
`define EBM_RD_BIT 0
`define EBM_WR_BIT 1
`define EBM_ROM_MSB_BIT 0
`define EBM_RDATA_RST 8'h00
`endif

// *** inc/ebm_pkg.sv ***
// types of the external byte memory port
// assumes nothing beyond a SystemVerilog compiler
package ebm_pkg;
  typedef enum logic [2:0] {
    EBM_IDLE = 3'b000,
    EBM_SETUP = 3'b001,
    EBM_STROBE = 3'b010,
    EBM_HOLD = 3'b011,
    EBM_DONE = 3'b100
  } ebm_state_e;
  typedef logic [3:0] ebm_cnt_t;
endpackage

// *** tb/ebm_mem_model.sv ***
// byte-wide external memory partner of the byte memory port
// assumes strobes and address come straight from the port's pins
module ebm_mem_model (
  input wire logic clock,
  input wire logic [15:0] addr,
  input wire logic [7:0] wdata,
  input wire logic rd_n,
  input wire logic wr_n,
  output logic [7:0] rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] mem [256];
  logic [7:0] last = 8'h5a;
  always @(posedge clock) begin
    if (!wr_n) mem[addr[7:0]] <= wdata;
    if (!rd_n) last <= mem[addr[7:0]];
  end
  // released bus shows the inverse of the last byte
  assign rdata = rd_n ? ~last : mem[addr[7:0]];
endmodule

// *** tb/ebm_port_monitor.sv ***
// concurrent checks on the byte memory port pins
// assumes binding to ebm_port, one clock domain
module ebm_port_monitor (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic xfer_busy,
  input wire logic xfer_done,
  input wire logic xfer_refused,
  input wire logic voice_busy,
  input wire logic voice_blocked,
  input wire logic strobe_port_secondary_sel,
  input wire logic [3:0] port8_pin_o,
  input wire logic [15:0] addr_pin_o,
  input wire logic [15:0] addr_pin_oe,
  input wire logic [15:0] addr_port_oe,
  input wire logic [7:0] data_pin_oe,
  input wire logic [3:0] port8_output_data,
  input wire logic ports_locked,
  input wire logic rom_req
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);
  a_busy_span: assert property ($rose(xfer_busy) |-> ##9 xfer_busy ##1 (!xfer_busy && xfer_done)) else $error("busy span wrong");
  a_rd_width: assert property ($fell(port8_pin_o[0]) |-> !port8_pin_o[0] [*6] ##1 port8_pin_o[0]) else $error("read strobe width");
  a_strobe_idle: assert property (strobe_port_secondary_sel && !xfer_busy |-> port8_pin_o[1:0] == 2'b11) else $error("strobe idle");
  a_addr_hold: assert property (!port8_pin_o[0] && strobe_port_secondary_sel |-> $stable(addr_pin_o)) else $error("addr moved");
  a_wr_drive: assert property (!port8_pin_o[1] && strobe_port_secondary_sel |-> data_pin_oe == 8'hff) else $error("write bus");
  a_rom_no_ext: assert property (rom_req && strobe_port_secondary_sel |-> port8_pin_o[1:0] == 2'b11) else $error("rom used ext");
  a_voice_excl: assert property ($rose(xfer_busy) |-> !$past(voice_busy) && voice_blocked) else $error("voice overlap");
  a_lock_oe: assert property (ports_locked == (port8_output_data[3:2] == 2'b01) && (!ports_locked || (addr_pin_oe == 16'h0000 && data_pin_oe == 8'h00))) else $error("lock");
  a_idle_follow: assert property (!xfer_busy && !ports_locked |-> addr_pin_oe == addr_port_oe) else $error("idle pins");
  a_refuse_idle: assert property (xfer_refused |-> !xfer_busy && !xfer_done) else $error("refuse busy");
endmodule
bind ebm_port ebm_port_monitor u_mon (.clock, .sys_rst, .xfer_busy, .xfer_done, .xfer_refused,
  .voice_busy, .voice_blocked, .strobe_port_secondary_sel, .port8_pin_o, .addr_pin_o,
  .addr_pin_oe, .addr_port_oe, .data_pin_oe, .port8_output_data, .ports_locked, .rom_req);

// *** tb/tb.sv ***
// self-checking bench for the byte memory port
// assumes ebm_port, the memory model and the bound monitor
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock = 0, sys_rst = 1, req = 0, we = 0, vbusy = 0, vext = 0;
  logic [2:0] vua = 3'h0;
  logic [15:0] xa = 16'h0, apo = 16'h0f0f, apoe = 16'hffff;
  logic [7:0] xd = 8'h0, dpo = 8'h3c, dpoe = 8'h00, mq, dpi, romd;
  logic [3:0] p8o = 4'hc, pfo = 4'h0;
  logic [3:0] sel [4] = '{4'h4, 4'h0, 4'h8, 4'hc};
  logic [16:0] rsn;
  wire busy, done, refd, vblk, rreq, lock;
  wire [7:0] rd, dpino, dpinoe;
  wire [15:0] ao, aoe;
  wire [3:0] p8po, p8poe, pfpo, pfpoe;
  wire [16:0] ra;
  int failures = 0, compares = 0;
  always #5 clock = ~clock;
  assign romd = ~ra[7:0] ^ {ra[16], 7'h0};
  assign dpi = (dpinoe & dpino) | (~dpinoe & mq);
  ebm_port uut (.clock, .sys_rst, .byte_transfer_instruction(req), .xfer_write(we),
    .xfer_address(xa), .xfer_wdata(xd), .xfer_busy(busy), .xfer_done(done),
    .xfer_refused(refd), .xfer_rdata(rd), .voice_busy(vbusy), .voice_ext_mem(vext),
    .voice_upper_address(vua), .voice_blocked(vblk), .address_ports_secondary_sel(1'b1),
    .strobe_port_secondary_sel(1'b1), .data_ports_secondary_sel(1'b1), .addr_port_out(apo),
    .addr_port_oe(apoe), .data_port_out(dpo), .data_port_oe(dpoe), .port8_output_data(p8o),
    .port8_direction(4'hc), .portf_output_data(pfo), .portf_direction(4'hf), .addr_pin_o(ao),
    .addr_pin_oe(aoe), .data_pin_i(dpi), .data_pin_o(dpino), .data_pin_oe(dpinoe),
    .port8_pin_o(p8po), .port8_pin_oe(p8poe), .portf_pin_o(pfpo), .portf_pin_oe(pfpoe),
    .rom_req(rreq), .rom_address(ra), .rom_rdata(romd), .ports_locked(lock));
  ebm_mem_model mem (.clock, .addr(ao), .wdata(dpino), .rd_n(p8po[0]), .wr_n(p8po[1]),
    .rdata(mq));
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] %0t saw %h want %h", $time, seen, exp);
    end
  endtask
  task automatic xfer(input logic w, input logic [15:0] a, input logic [7:0] d, input logic r);
    int n;
    n = 0;
    @(posedge clock) req <= 1;
    we <= w;
    xa <= a;
    xd <= d;
    do begin
      @(posedge clock);
      #1;
      n++;
      if (rreq === 1'b1) rsn = ra;
    end while (done !== 1'b1 && refd !== 1'b1 && n < 40);
    chk(refd, r);
    chk(n, r ? 1 : 11);
    @(posedge clock) req <= 0;
    repeat (2) @(posedge clock);
  endtask
  task automatic summarize();
    $display("compares=%0d failures=%0d", compares, failures);
    if (failures == 0 && compares > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  initial begin
    #50000;
    failures++;
    summarize();
  end
  initial begin
    repeat (2) @(posedge clock);
    sys_rst <= 0;
    @(posedge clock);
    #1;
    chk(rd, 8'h00);
    chk(p8po[1:0], 2'b11);
    chk(aoe, apoe);
    chk(dpinoe, dpoe);
    // port 8 value 4'hc selects external memory; the port drives the write strobe itself here
    xfer(1, 16'h1234, 8'ha5, 0);
    xfer(1, 16'hff00, 8'h5a, 0);
    xfer(0, 16'h1234, 8'h00, 0);
    chk(rd, 8'ha5);
    xfer(0, 16'hff00, 8'h00, 0);
    chk(rd, 8'h5a);
    chk(ao, apo);
    @(posedge clock) p8o <= 4'h4;
    pfo <= 4'h1;
    xfer(0, 16'h0042, 8'h00, 0);
    chk(rd, 8'h3d);
    chk(rsn, 17'h10042);
    chk(lock, 1'b1);
    chk(aoe, 16'h0000);
    for (int i = 0; i < 4; i++) begin
      @(posedge clock) p8o <= sel[i];
      vbusy <= (i == 3);
      xfer(i == 0, 16'h0042, 8'h00, 1);
    end
    @(posedge clock) vbusy <= 0;
    vext <= 1;
    vua <= 3'h5;
    pfo <= 4'h2;
    @(posedge clock);
    #1;
    chk(pfpo[2:0], 3'h5);
    @(posedge clock) vext <= 0;
    @(posedge clock);
    #1;
    chk(pfpo[2:0], 3'h2);
    summarize();
  end
endmodule
